/* File: core/sws_pkg.sv */
// types shared by the standby/wake/boot sequencer
`default_nettype none
package sws_pkg;
	typedef enum logic [2:0] {
		SWS_STANDBY,
		SWS_OSC_START,
		SWS_BOOT_FIXED,
		SWS_COPY,
		SWS_RUN
	} sws_state_t;
	typedef enum logic [1:0] {
		SWS_X_IDLE,
		SWS_X_START,
		SWS_X_MEAS
	} sws_xo_state_t;
	typedef struct packed {
		logic we;
		logic [11:0] addr;
		logic [7:0] data;
	} sws_ram_wr_t;
endpackage
`default_nettype wire

/* File: core/sws_regs.svh */
// timing, size and reset constants of the standby/wake/boot sequencer
`ifndef SWS_REGS_SVH
`define SWS_REGS_SVH
`define SWS_CLK_NS 25
`define SWS_BOOT_FIXED_US 2000
`define SWS_BOOT_PER_KB_US 3600
`define SWS_BOOT_FIXED_CYC ((`SWS_BOOT_FIXED_US * 1000) / `SWS_CLK_NS)
`define SWS_KB_CYC ((`SWS_BOOT_PER_KB_US * 1000) / `SWS_CLK_NS)
`define SWS_KB_BYTES 1024
`define SWS_BYTE_CYC (`SWS_KB_CYC / `SWS_KB_BYTES)
`define SWS_RAM_KB 4
`define SWS_OSC_START_NS 1000
`define SWS_OSC_START_CYC ((`SWS_OSC_START_NS + `SWS_CLK_NS - 1) / `SWS_CLK_NS)
`define SWS_SLEEP_UNIT_US 1000
`define SWS_SLEEP_UNIT_CYC ((`SWS_SLEEP_UNIT_US * 1000) / `SWS_CLK_NS)
`define SWS_XO_START_MS 50
`define SWS_XO_START_CYC ((`SWS_XO_START_MS * 1000000) / `SWS_CLK_NS)
`define SWS_FC_WIN_CYC 1024
`define SWS_RET_BYTES 8
`define SWS_GPIO_W 8
`define SWS_PERIPH_W 8
`define SWS_DIV_MAX_LOG 7
`define SWS_RET_RST 8'h00
`endif

/* File: core/sws_seq.sv */
// standby, wake, boot copy and clock control sequencer
`include "sws_regs.svh"
`default_nettype none
module sws_seq
	import sws_pkg::*;
#(
	parameter int BOOT_FIXED_CYC = `SWS_BOOT_FIXED_CYC,
	parameter int BYTE_CYC = `SWS_BYTE_CYC,
	parameter int SLEEP_UNIT_CYC = `SWS_SLEEP_UNIT_CYC,
	parameter int XO_START_CYC = `SWS_XO_START_CYC
) (
	// clock and power-on reset
	input wire logic clk_in,
	input wire logic rst_in,
	// wake sources
	input wire logic [`SWS_GPIO_W-1:0] gpio_in,
	input wire logic sleep_en_in,
	input wire logic [22:0] sleep_ticks_in,
	// processor control
	input wire logic sleep_req_in,
	input wire logic [2:0] copy_kb_in,
	input wire logic [2:0] clk_div_sel_in,
	output logic cpu_run_out,
	output logic sys_tick_out,
	output logic timer_tick_out,
	// program store read and ram fill
	output logic otp_rd_out,
	output logic [11:0] otp_addr_out,
	input wire logic [7:0] otp_data_in,
	output sws_ram_wr_t ram_wr_out,
	// retention memory
	input wire logic ret_we_in,
	input wire logic [2:0] ret_addr_in,
	input wire logic [7:0] ret_wdata_in,
	output logic [7:0] ret_rdata_out,
	// oscillators and calibration
	output logic low_power_osc_en_out,
	input wire logic crystal_en_in,
	input wire logic crystal_low_cap_sel_in,
	input wire logic crystal_clk_in,
	input wire logic tx_req_in,
	output logic crystal_osc_en_out,
	output logic crystal_low_cap_sel_out,
	output logic lc_osc_a_cal_out,
	output logic [15:0] freq_ratio_out,
	output logic tx_start_out,
	// power switches
	input wire logic [`SWS_PERIPH_W-1:0] periph_off_in,
	input wire logic all_off_in,
	input wire logic analog_used_in,
	output logic [`SWS_PERIPH_W-1:0] periph_pwr_out,
	output logic bandgap_en_out
);
	sws_state_t state_q;
	sws_xo_state_t xo_q;
	logic [`SWS_GPIO_W-1:0] gpio_s1_q, gpio_s2_q, gpio_s3_q;
	logic [1:0] xclk_sync_q;
	logic xclk_prev_q;
	logic pin_wake, timer_wake, wake, copy_last;
	logic [22:0] sleep_cnt_q;
	logic [15:0] unit_cnt_q;
	logic [25:0] wait_q;
	logic [12:0] byte_q;
	logic [12:0] copy_len;
	logic rd_pend_q;
	logic [6:0] div_q;
	logic [15:0] fc_cnt_q;
	logic [10:0] fc_win_q;
	logic [7:0] ret_mem [`SWS_RET_BYTES];

	// pin and crystal edges are judged on synchronised samples only
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			gpio_s1_q <= '1;
			gpio_s2_q <= '1;
			gpio_s3_q <= '1;
			xclk_sync_q <= 2'h0;
			xclk_prev_q <= 1'b0;
		end else begin
			gpio_s1_q <= gpio_in;
			gpio_s2_q <= gpio_s1_q;
			gpio_s3_q <= gpio_s2_q;
			xclk_sync_q <= {xclk_sync_q[0], crystal_clk_in};
			xclk_prev_q <= xclk_sync_q[1];
		end
	end
	assign pin_wake = |(gpio_s3_q & ~gpio_s2_q);

	// sleep timer counts whole units only while in standby
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			unit_cnt_q <= 16'h0000;
			sleep_cnt_q <= 23'h000000;
		end else if (state_q != SWS_STANDBY || !sleep_en_in) begin
			unit_cnt_q <= 16'h0000;
			sleep_cnt_q <= 23'h000000;
		end else if (unit_cnt_q == 16'(SLEEP_UNIT_CYC - 1)) begin
			unit_cnt_q <= 16'h0000;
			sleep_cnt_q <= sleep_cnt_q + 23'h000001;
		end else begin
			unit_cnt_q <= unit_cnt_q + 16'h0001;
		end
	end
	assign timer_wake = sleep_en_in && sleep_ticks_in != 23'h000000 &&
		sleep_cnt_q >= sleep_ticks_in;
	assign wake = pin_wake || timer_wake;

	// copy length clamped to the ram size
	assign copy_len = (copy_kb_in > 3'(`SWS_RAM_KB)) ? 13'(`SWS_RAM_KB * `SWS_KB_BYTES) :
		13'({copy_kb_in, 10'h000});
	assign copy_last = byte_q == copy_len - 13'h0001;

	// main sequence; reset lands in standby with the processor held
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= SWS_STANDBY;
			wait_q <= 26'h0000000;
			byte_q <= 13'h0000;
		end else begin
			unique case (state_q)
				SWS_STANDBY: begin
					wait_q <= 26'h0000000;
					byte_q <= 13'h0000;
					if (wake) state_q <= SWS_OSC_START;
				end
				SWS_OSC_START: begin
					wait_q <= wait_q + 26'h0000001;
					if (wait_q == 26'(`SWS_OSC_START_CYC - 1)) begin
						wait_q <= 26'h0000000;
						state_q <= SWS_BOOT_FIXED;
					end
				end
				SWS_BOOT_FIXED: begin
					wait_q <= wait_q + 26'h0000001;
					if (wait_q == 26'(BOOT_FIXED_CYC - 1)) begin
						wait_q <= 26'h0000000;
						state_q <= (copy_len == 13'h0000) ? SWS_RUN : SWS_COPY;
					end
				end
				SWS_COPY: begin
					wait_q <= wait_q + 26'h0000001;
					if (wait_q == 26'(BYTE_CYC - 1)) begin
						wait_q <= 26'h0000000;
						byte_q <= byte_q + 13'h0001;
						if (copy_last) state_q <= SWS_RUN;
					end
				end
				SWS_RUN: begin
					if (sleep_req_in) state_q <= SWS_STANDBY;
				end
			endcase
		end
	end

	// one program-store read per byte slot, written to ram two cycles later
	assign otp_rd_out = state_q == SWS_COPY && wait_q == 26'h0000000;
	assign otp_addr_out = byte_q[11:0];
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_pend_q <= 1'b0;
			ram_wr_out <= '0;
		end else begin
			rd_pend_q <= otp_rd_out;
			ram_wr_out.we <= rd_pend_q;
			if (otp_rd_out) ram_wr_out.addr <= byte_q[11:0];
			if (rd_pend_q) ram_wr_out.data <= otp_data_in;
		end
	end
	// the processor never sees the program store; only the copy engine reads it
	assign cpu_run_out = state_q == SWS_RUN;

	// oscillator runs in every state but standby
	assign low_power_osc_en_out = state_q != SWS_STANDBY;

	// power-of-two divider; ticks stand in for gated clock edges
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			div_q <= 7'h00;
		end else begin
			div_q <= low_power_osc_en_out ? div_q + 7'h01 : 7'h00;
		end
	end
	assign sys_tick_out = low_power_osc_en_out &&
		(div_q & ((7'h01 << clk_div_sel_in) - 7'h01)) == 7'h00;
	assign timer_tick_out = low_power_osc_en_out;
	// retention memory has no reset: its content must outlive standby and wake
	always_ff @(posedge clk_in) begin
		if (ret_we_in && cpu_run_out) ret_mem[ret_addr_in] <= ret_wdata_in;
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ret_rdata_out <= `SWS_RET_RST;
		end else begin
			ret_rdata_out <= ret_mem[ret_addr_in];
		end
	end

	// crystal sequence: start, count its edges over a window, then stop
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			xo_q <= SWS_X_IDLE;
			fc_win_q <= 11'h000;
			fc_cnt_q <= 16'h0000;
			freq_ratio_out <= 16'h0000;
			tx_start_out <= 1'b0;
		end else begin
			tx_start_out <= 1'b0;
			unique case (xo_q)
				SWS_X_IDLE: begin
					fc_win_q <= 11'h000;
					fc_cnt_q <= 16'h0000;
					if (tx_req_in && cpu_run_out) begin
						xo_q <= crystal_en_in ? SWS_X_START : SWS_X_IDLE;
						tx_start_out <= !crystal_en_in;
					end
				end
				SWS_X_START: begin
					fc_cnt_q <= fc_cnt_q + 16'h0001;
					if (!cpu_run_out) begin
						xo_q <= SWS_X_IDLE;
					end else if (fc_cnt_q == 16'((XO_START_CYC - 1) / `SWS_FC_WIN_CYC)) begin
						fc_cnt_q <= 16'h0000;
						xo_q <= SWS_X_MEAS;
					end
				end
				SWS_X_MEAS: begin
					fc_win_q <= fc_win_q + 11'h001;
					if (xclk_sync_q[1] && !xclk_prev_q) fc_cnt_q <= fc_cnt_q + 16'h0001;
					if (!cpu_run_out) begin
						xo_q <= SWS_X_IDLE;
					end else if (fc_win_q == 11'(`SWS_FC_WIN_CYC - 1)) begin
						freq_ratio_out <= fc_cnt_q;
						tx_start_out <= 1'b1;
						xo_q <= SWS_X_IDLE;
					end
				end
			endcase
		end
	end
	assign crystal_osc_en_out = xo_q != SWS_X_IDLE;
	assign crystal_low_cap_sel_out = crystal_low_cap_sel_in;
	assign lc_osc_a_cal_out = xo_q == SWS_X_MEAS;

	// software power switches, all forced off in standby
	assign periph_pwr_out = cpu_run_out && !all_off_in ? ~periph_off_in : '0;
	assign bandgap_en_out = cpu_run_out && analog_used_in;

	a_standby_after_rst: assert property (@(posedge clk_in)
		$fell(rst_in) |-> state_q == SWS_STANDBY && !cpu_run_out) else $error("not standby");
	a_standby_power_off: assert property (@(posedge clk_in) disable iff (rst_in)
		state_q == SWS_STANDBY |-> !low_power_osc_en_out && periph_pwr_out == '0
		&& !bandgap_en_out) else $error("power in standby");
	a_pin_wake_starts: assert property (@(posedge clk_in) disable iff (rst_in)
		state_q == SWS_STANDBY && pin_wake |=> state_q == SWS_OSC_START)
		else $error("pin wake lost");
	a_timer_wake_starts: assert property (@(posedge clk_in) disable iff (rst_in)
		state_q == SWS_STANDBY && timer_wake |=> state_q == SWS_OSC_START)
		else $error("timer wake lost");
	a_copy_after_fixed: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(state_q == SWS_COPY) |-> $past(state_q) == SWS_BOOT_FIXED
		&& $past(wait_q) == 26'(BOOT_FIXED_CYC - 1)) else $error("fixed wait short");
	a_read_then_write: assert property (@(posedge clk_in) disable iff (rst_in)
		otp_rd_out |=> ##1 ram_wr_out.we && ram_wr_out.addr == $past(otp_addr_out, 2))
		else $error("copy byte lost");
	a_run_after_copy: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(cpu_run_out) |-> $past(state_q) inside {SWS_COPY, SWS_BOOT_FIXED})
		else $error("run before copy");
	a_otp_only_copy: assert property (@(posedge clk_in) disable iff (rst_in)
		otp_rd_out |-> state_q == SWS_COPY && !cpu_run_out) else $error("otp read in run");
	a_div_tick: assert property (@(posedge clk_in) disable iff (rst_in)
		sys_tick_out && clk_div_sel_in == 3'h7 ##1 clk_div_sel_in == 3'h7 |-> !sys_tick_out)
		else $error("bad divide");
	a_xo_stops: assert property (@(posedge clk_in) disable iff (rst_in)
		xo_q == SWS_X_MEAS && fc_win_q == 11'(`SWS_FC_WIN_CYC - 1) && cpu_run_out
		|=> !crystal_osc_en_out && tx_start_out) else $error("crystal left on");
	c_pin_wake: cover property (@(posedge clk_in) disable iff (rst_in)
		state_q == SWS_STANDBY && pin_wake);
	c_timer_wake: cover property (@(posedge clk_in) disable iff (rst_in)
		state_q == SWS_STANDBY && timer_wake);
	c_boot_done: cover property (@(posedge clk_in) disable iff (rst_in) $rose(cpu_run_out));
	c_xo_cal: cover property (@(posedge clk_in) disable iff (rst_in)
		tx_start_out && xo_q == SWS_X_IDLE && $past(xo_q) == SWS_X_MEAS);
endmodule
`default_nettype wire

/* File: tb/standby_wake_boot_sequencer_bench.sv */
// self-checking bench of the standby/wake/boot sequencer
`default_nettype none
module standby_wake_boot_sequencer_bench import sws_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [2:0] sel;
		logic [7:0] off;
		logic all;
		logic ana;
		logic [15:0] ticks;
		logic [7:0] pwr;
		logic bg;
	} sws_row_t;
	logic clk_in = 1'b0, rst_in = 1'b1, xclk = 1'b0, low_cap = 1'b1;
	logic [7:0] gpio = 8'hFF, otp_data, periph_off = 8'h00, ret_wdata = 8'h00;
	logic sleep_en = 1'b0, sleep_req = 1'b0, ret_we = 1'b0, xo_en = 1'b0;
	logic tx_req = 1'b0, all_off = 1'b0, analog = 1'b0;
	logic [22:0] sleep_ticks = 23'h000003;
	logic [2:0] copy_kb = 3'h1, div_sel = 3'h0, ret_addr = 3'h5;
	logic cpu_run, sys_tick, timer_tick, otp_rd, osc_en, xo_out, cap_out, lc_cal;
	logic tx_start, bg_en;
	logic [11:0] otp_addr;
	logic [11:0] exp_addr = 12'h000;
	logic [15:0] ratio;
	logic [7:0] ret_rdata, pwr;
	sws_ram_wr_t ram_wr;
	int err_total = 0, cmp_count = 0, n, ticks, wr_cnt = 0;
	sws_row_t rows [8] = '{
		'{3'h0, 8'h0F, 1'b0, 1'b0, 16'h0100, 8'hF0, 1'b0},
		'{3'h1, 8'h00, 1'b0, 1'b1, 16'h0080, 8'hFF, 1'b1},
		'{3'h2, 8'hFF, 1'b0, 1'b0, 16'h0040, 8'h00, 1'b0},
		'{3'h3, 8'h3C, 1'b1, 1'b1, 16'h0020, 8'h00, 1'b1},
		'{3'h4, 8'h81, 1'b0, 1'b1, 16'h0010, 8'h7E, 1'b1},
		'{3'h5, 8'h00, 1'b1, 1'b0, 16'h0008, 8'h00, 1'b0},
		'{3'h6, 8'hA5, 1'b0, 1'b0, 16'h0004, 8'h5A, 1'b0},
		'{3'h7, 8'h00, 1'b0, 1'b1, 16'h0002, 8'hFF, 1'b1}};

	initial begin
		forever #12.5 clk_in = ~clk_in;
	end
	// crystal runs free and unrelated in phase to the system clock
	initial begin
		forever #45 xclk = ~xclk;
	end

	sws_seq #(.BOOT_FIXED_CYC(20), .BYTE_CYC(4), .SLEEP_UNIT_CYC(5), .XO_START_CYC(2048)) uut (
		.clk_in(clk_in), .rst_in(rst_in), .gpio_in(gpio), .sleep_en_in(sleep_en),
		.sleep_ticks_in(sleep_ticks), .sleep_req_in(sleep_req), .copy_kb_in(copy_kb),
		.clk_div_sel_in(div_sel), .cpu_run_out(cpu_run), .sys_tick_out(sys_tick),
		.timer_tick_out(timer_tick), .otp_rd_out(otp_rd), .otp_addr_out(otp_addr),
		.otp_data_in(otp_data), .ram_wr_out(ram_wr), .ret_we_in(ret_we),
		.ret_addr_in(ret_addr), .ret_wdata_in(ret_wdata), .ret_rdata_out(ret_rdata),
		.low_power_osc_en_out(osc_en), .crystal_en_in(xo_en), .crystal_low_cap_sel_in(low_cap),
		.crystal_clk_in(xclk), .tx_req_in(tx_req), .crystal_osc_en_out(xo_out),
		.crystal_low_cap_sel_out(cap_out), .lc_osc_a_cal_out(lc_cal), .freq_ratio_out(ratio),
		.tx_start_out(tx_start), .periph_off_in(periph_off), .all_off_in(all_off),
		.analog_used_in(analog), .periph_pwr_out(pwr), .bandgap_en_out(bg_en));
	sws_otp_model otp (.clk_in(clk_in), .otp_rd_in(otp_rd), .otp_addr_in(otp_addr),
		.otp_data_out(otp_data));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		if (err_total == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic logic probe(input int which);
		case (which)
			0: return osc_en;
			1: return cpu_run;
			2: return tx_start;
			default: return xo_out;
		endcase
	endfunction
	// n ends as the number of cycles waited
	task automatic wait_hi(input int which, input int lim);
		n = 0;
		#1;
		while (probe(which) !== 1'b1) begin
			@(posedge clk_in);
			#1 n++;
			if (n > lim) begin
				chk(16'h0001, 16'h0000);
				finish_test;
			end
		end
	endtask

	always @(posedge clk_in) begin
		if (otp_rd && cpu_run)
			chk(16'h0001, 16'h0000);
		if (ram_wr.we) begin
			chk({4'h0, ram_wr.addr}, {4'h0, exp_addr});
			chk({8'h00, ram_wr.data}, {8'h00, exp_addr[7:0] ^ 8'h5A});
			exp_addr <= exp_addr + 12'h001;
			wr_cnt <= wr_cnt + 1;
		end
	end

	initial begin
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (30) @(posedge clk_in);
		#1 chk({14'h0, cpu_run, osc_en}, 16'h0000);
		chk({7'h00, pwr, bg_en}, 16'h0000);
		chk({15'h0, timer_tick}, 16'h0000);
		@(posedge clk_in);
		gpio <= 8'hF7;
		wait_hi(0, 6);
		wait_hi(1, 4200);
		chk({14'h0, n > 4140, n < 4175}, 16'h0003);
		chk(wr_cnt[15:0], 16'h0400);
		chk({14'h0, timer_tick, cap_out}, 16'h0003);
		foreach (rows[i]) begin
			@(posedge clk_in);
			div_sel <= rows[i].sel;
			periph_off <= rows[i].off;
			all_off <= rows[i].all;
			analog <= rows[i].ana;
			ticks = 0;
			@(posedge clk_in);
			repeat (256) begin
				@(posedge clk_in);
				#1 ticks += sys_tick;
			end
			chk(ticks[15:0], rows[i].ticks);
			chk({7'h00, pwr, bg_en}, {7'h00, rows[i].pwr, rows[i].bg});
		end
		@(posedge clk_in);
		ret_we <= 1'b1;
		ret_wdata <= 8'h3C;
		tx_req <= 1'b1;
		@(posedge clk_in);
		ret_we <= 1'b0;
		tx_req <= 1'b0;
		wait_hi(2, 3);
		@(posedge clk_in);
		xo_en <= 1'b1;
		tx_req <= 1'b1;
		low_cap <= 1'b0;
		@(posedge clk_in);
		tx_req <= 1'b0;
		wait_hi(3, 3);
		chk({13'h0000, xo_out, lc_cal, cap_out}, 16'h0004);
		repeat (2) @(posedge clk_in);
		#1 chk({13'h0000, xo_out, lc_cal, cap_out}, 16'h0006);
		wait_hi(2, 3200);
		chk({14'h0000, xo_out, lc_cal}, 16'h0000);
		chk({14'h0, ratio > 16'h0119, ratio < 16'h0120}, 16'h0003);
		@(posedge clk_in);
		sleep_req <= 1'b1;
		copy_kb <= 3'h0;
		@(posedge clk_in);
		sleep_req <= 1'b0;
		sleep_en <= 1'b1;
		#1 chk({6'h00, cpu_run, osc_en, pwr}, 16'h0000);
		// timer wake with no copy: oscillator start plus fixed boot only
		wait_hi(0, 40);
		chk({15'h0000, n > 10}, 16'h0001);
		wait_hi(1, 100);
		chk({14'h0, n > 55, n < 70}, 16'h0003);
		chk({8'h00, ret_rdata}, 16'h003C);
		@(posedge clk_in);
		rst_in <= 1'b1;
		sleep_en <= 1'b0;
		@(posedge clk_in);
		#1 chk({14'h0, cpu_run, osc_en}, 16'h0000);
		finish_test;
	end
endmodule
`default_nettype wire

/* File: tb/sws_otp_model.sv */
// program store model: answers a read one cycle later
`default_nettype none
module sws_otp_model (
	// clock and read request
	input wire logic clk_in,
	input wire logic otp_rd_in,
	input wire logic [11:0] otp_addr_in,
	// read data
	output logic [7:0] otp_data_out = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus inverts its own value every cycle so stale data cannot pass as fresh
	always @(posedge clk_in) begin
		if (otp_rd_in)
			otp_data_out <= otp_addr_in[7:0] ^ 8'h5A;
		else
			otp_data_out <= ~otp_data_out;
	end
endmodule
`default_nettype wire
